/* File: src/mlsf_pkg.sv */
/*
  Constants and carriers for the monitor limit status flags.
  Assumes conversion results arrive one channel at a time from the sequencer.
*/
package mlsf_pkg;

  // Register offsets on the status read port
  localparam logic [7:0] TEMP_AND_RAIL_STATUS_OFS = 8'h20;
  localparam logic [7:0] ANALOG_INPUT_STATUS_OFS  = 8'h21;
  localparam logic [7:0] FAN_TACH_STATUS_OFS      = 8'h22;
  localparam logic [7:0] STATUS_RESET_VAL         = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VAL        = 8'h00;

  // Flag positions in the 24-bit flag vector
  localparam int FLAG_WIDTH     = 24;
  localparam int FLAG_REMOTE_A  = 0;
  localparam int FLAG_REMOTE_B  = 1;
  localparam int FLAG_RAIL_BASE = 2;
  localparam int FLAG_AIN_BASE  = 8;
  localparam int FLAG_TACH_BASE = 16;
  localparam int FLAG_NONE      = 31;

  // Conversion channel codes
  localparam logic [4:0] CH_REMOTE_TEMP_A   = 5'h00;
  localparam logic [4:0] CH_REMOTE_TEMP_B   = 5'h01;
  localparam logic [4:0] CH_AUX_ANALOG_NINE = 5'h02;
  localparam logic [4:0] CH_RAIL_FIRST      = 5'h03;
  localparam logic [4:0] CH_RAIL_LAST       = 5'h08;
  localparam logic [4:0] CH_AIN_FIRST       = 5'h09;
  localparam logic [4:0] CH_AIN_LAST        = 5'h10;
  localparam logic [4:0] CH_TACH_FIRST      = 5'h11;
  localparam logic [4:0] CH_TACH_LAST       = 5'h18;

  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
    logic [7:0] value;
    logic [7:0] high_limit;
    logic [7:0] low_limit;
  } mlsf_conv_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
  } mlsf_rd_req_t;

endpackage

/* File: src/mlsf_window_check.sv */
/*
  Window comparator for one converted value.
  Assumes value and limits share one unsigned 8-bit scale.
*/
`timescale 1ns/100ps
module mlsf_window_check (
  // Value and its limits
  input  wire logic [7:0] value,
  input  wire logic [7:0] high_limit,
  input  wire logic [7:0] low_limit,
  // Mode and result
  input  wire logic       high_only,
  output logic            outside
);

  always_comb begin
    outside = (value > high_limit) || (!high_only && (value < low_limit));
  end

endmodule

/* File: src/mlsf_status.sv */
/*
  Limit status flags: three read-only status registers refreshed per conversion.
  Assumes one conversion result per cycle at most, and mask words held elsewhere.
*/
`timescale 1ns/100ps
// What this block does
// R1: Bit 0 of first register flags remote_temp_a outside its window at its last conversion.
// R2: remote_temp_a flag is set once on entering thermal_alarm mode.
// R3: remote_temp_a flag is set once on leaving thermal_alarm mode.
// R4: Bit 1 checks remote_temp_b, or aux_analog_nine in voltage mode.
// R5: remote_temp_b flag is set once on entering and once on leaving alarm, outside voltage mode.
// R6: Bits 2 to 7 flag the six supply rails in fixed order.
// R7: Second register bits flag analog inputs 0 to 7 outside window.
// R8: Third register flags tachometers above high limit only.
// R9: All three registers are read-only and zero after reset.
// R10: A set mask bit blocks the channel's event but not its flag.
// R11: Each flag is refreshed when its channel converts, clearing when back in limits unless an alarm transition sets bit 0 or 1 in that cycle.
module mlsf_status (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // Conversion results
  input  wire mlsf_pkg::mlsf_conv_t  conv_in,
  input  wire logic                  remote_b_voltage_mode,
  // Thermal alarm mode levels
  input  wire logic                  thermal_alarm_a,
  input  wire logic                  thermal_alarm_b,
  // Channel masks
  input  wire logic [23:0]           event_mask,
  // Status read port
  input  wire mlsf_pkg::mlsf_rd_req_t rd_req,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid,
  // Unmasked out-of-limit events
  output logic [23:0]                limit_event
);

  logic [23:0] flags_reg;
  logic [23:0] flags_next;
  logic [23:0] event_reg;
  logic [23:0] event_next;
  logic [7:0]  rd_data_reg;
  logic [7:0]  rd_data_next;
  logic        rd_valid_reg;
  logic        rd_valid_next;
  logic        alarm_a_reg;
  logic        alarm_a_next;
  logic        alarm_b_reg;
  logic        alarm_b_next;
  logic        outside;
  logic        is_tach;
  int          flag_idx;
  logic        alarm_a_edge;
  logic        alarm_b_edge;

  function automatic int map_flag(input logic [4:0] ch, input logic vmode);
    int idx;
    idx = mlsf_pkg::FLAG_NONE;
    if (ch == mlsf_pkg::CH_REMOTE_TEMP_A) begin
      idx = mlsf_pkg::FLAG_REMOTE_A;
    end else if (ch == mlsf_pkg::CH_REMOTE_TEMP_B) begin
      idx = vmode ? mlsf_pkg::FLAG_NONE : mlsf_pkg::FLAG_REMOTE_B;
    end else if (ch == mlsf_pkg::CH_AUX_ANALOG_NINE) begin
      idx = vmode ? mlsf_pkg::FLAG_REMOTE_B : mlsf_pkg::FLAG_NONE;
    end else if (ch >= mlsf_pkg::CH_RAIL_FIRST && ch <= mlsf_pkg::CH_RAIL_LAST) begin
      idx = mlsf_pkg::FLAG_RAIL_BASE + int'(ch - mlsf_pkg::CH_RAIL_FIRST);
    end else if (ch >= mlsf_pkg::CH_AIN_FIRST && ch <= mlsf_pkg::CH_AIN_LAST) begin
      idx = mlsf_pkg::FLAG_AIN_BASE + int'(ch - mlsf_pkg::CH_AIN_FIRST);
    end else if (ch >= mlsf_pkg::CH_TACH_FIRST && ch <= mlsf_pkg::CH_TACH_LAST) begin
      idx = mlsf_pkg::FLAG_TACH_BASE + int'(ch - mlsf_pkg::CH_TACH_FIRST);
    end
    return idx;
  endfunction

  always_comb begin
    is_tach  = (conv_in.chan >= mlsf_pkg::CH_TACH_FIRST)
            && (conv_in.chan <= mlsf_pkg::CH_TACH_LAST);
    flag_idx = conv_in.valid ? map_flag(conv_in.chan, remote_b_voltage_mode)
                             : mlsf_pkg::FLAG_NONE;
  end

  mlsf_window_check u_window (
    .value      (conv_in.value),
    .high_limit (conv_in.high_limit),
    .low_limit  (conv_in.low_limit),
    .high_only  (is_tach),                                  // see R8
    .outside    (outside)
  );

  always_comb begin
    flags_next    = flags_reg;
    event_next    = '0;
    alarm_a_next  = thermal_alarm_a;
    alarm_b_next  = thermal_alarm_b;
    alarm_a_edge  = thermal_alarm_a ^ alarm_a_reg;          // see R2 see R3
    alarm_b_edge  = (thermal_alarm_b ^ alarm_b_reg) && !remote_b_voltage_mode; // see R5
    // Conversion result refreshes its own flag
    if (flag_idx < mlsf_pkg::FLAG_WIDTH) begin
      flags_next[flag_idx] = outside;                       // see R1 see R4 see R6 see R7 see R11
      event_next[flag_idx] = outside && !event_mask[flag_idx]; // see R10
    end
    // Alarm transitions win over a same-cycle clear
    if (alarm_a_edge) begin
      flags_next[mlsf_pkg::FLAG_REMOTE_A] = 1'b1;           // see R2 see R3
    end
    if (alarm_b_edge) begin
      flags_next[mlsf_pkg::FLAG_REMOTE_B] = 1'b1;           // see R5
    end
    rd_valid_next = rd_req.en;
    rd_data_next  = rd_data_reg;
    if (rd_req.en) begin
      unique case (rd_req.addr)
        mlsf_pkg::TEMP_AND_RAIL_STATUS_OFS: rd_data_next = flags_reg[7:0];
        mlsf_pkg::ANALOG_INPUT_STATUS_OFS:  rd_data_next = flags_reg[15:8];
        mlsf_pkg::FAN_TACH_STATUS_OFS:      rd_data_next = flags_reg[23:16];
        default:                            rd_data_next = mlsf_pkg::UNMAPPED_READ_VAL;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_reg    <= {3{mlsf_pkg::STATUS_RESET_VAL}};       // see R9
      event_reg    <= '0;
      rd_data_reg  <= mlsf_pkg::STATUS_RESET_VAL;
      rd_valid_reg <= 1'b0;
      alarm_a_reg  <= 1'b0;
      alarm_b_reg  <= 1'b0;
    end else begin
      flags_reg    <= flags_next;
      event_reg    <= event_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      alarm_a_reg  <= alarm_a_next;
      alarm_b_reg  <= alarm_b_next;
    end
  end

  assign rd_data     = rd_data_reg;
  assign rd_valid    = rd_valid_reg;
  assign limit_event = event_reg;

  a_reset_clears_flags: assert property (@(posedge core_clk) // see R9
    reset |=> (flags_reg == '0 && rd_data == 8'h00 && !rd_valid && limit_event == '0))
    else $error("flags not zero after reset");

  a_remote_a_window: assert property (@(posedge core_clk) disable iff (reset) // see R1
    ($past(flag_idx == 0) && !$past(alarm_a_edge)) |-> flags_reg[0] == $past(outside))
    else $error("remote_temp_a flag does not follow window");

  a_alarm_a_sets: assert property (@(posedge core_clk) disable iff (reset) // see R2
    ($rose(thermal_alarm_a) && !$past(reset)) |=> flags_reg[0])
    else $error("alarm entry did not set remote_temp_a flag");

  a_alarm_a_exit: assert property (@(posedge core_clk) disable iff (reset) // see R3
    ($fell(thermal_alarm_a) && !$past(reset)) |=> flags_reg[0])
    else $error("alarm exit did not set remote_temp_a flag");

  a_bit1_source: assert property (@(posedge core_clk) disable iff (reset) // see R4
    (conv_in.valid && conv_in.chan == 5'h02 && remote_b_voltage_mode && !alarm_b_edge)
    |=> flags_reg[1] == $past(outside))
    else $error("bit 1 does not follow aux_analog_nine in voltage mode");

  a_alarm_b_sets: assert property (@(posedge core_clk) disable iff (reset) // see R5
    ($changed(thermal_alarm_b) && !$past(reset) && !remote_b_voltage_mode) |=> flags_reg[1])
    else $error("alarm transition did not set remote_temp_b flag");

  a_rail_order: assert property (@(posedge core_clk) disable iff (reset) // see R6
    (conv_in.valid && conv_in.chan == 5'h08) |=> flags_reg[7] == $past(outside))
    else $error("last rail flag misplaced");

  a_analog_flag: assert property (@(posedge core_clk) disable iff (reset) // see R7
    (conv_in.valid && conv_in.chan == 5'h09) |=> flags_reg[8] == $past(outside))
    else $error("analog_in_0 flag misplaced");

  a_tach_high_only: assert property (@(posedge core_clk) disable iff (reset) // see R8
    (conv_in.valid && conv_in.chan == 5'h11 && conv_in.value <= conv_in.high_limit)
    |=> !flags_reg[16])
    else $error("tach flag set below high limit");

  a_mask_blocks: assert property (@(posedge core_clk) disable iff (reset) // see R10
    (flag_idx < 24 && event_mask[flag_idx]) |=> limit_event == '0)
    else $error("masked channel produced event");

  a_flag_clears: assert property (@(posedge core_clk) disable iff (reset) // see R11
    (conv_in.valid && conv_in.chan == 5'h0A && !outside) |=> !flags_reg[9])
    else $error("flag did not clear on in-limit conversion");

  a_read_second: assert property (@(posedge core_clk) disable iff (reset) // see R9
    (rd_req.en && rd_req.addr == 8'h21) |=> (rd_valid && rd_data == $past(flags_reg[15:8])))
    else $error("second register read wrong");

  a_mask_keeps_flag: assert property (@(posedge core_clk) disable iff (reset) // see R10
    (conv_in.valid && conv_in.chan == 5'h03 && event_mask[2] && outside) |=> flags_reg[2])
    else $error("masked channel lost its flag");

  a_event_idle: assert property (@(posedge core_clk) disable iff (reset) // see R10
    !conv_in.valid |=> limit_event == '0)
    else $error("event without a conversion");

  a_tach_over: assert property (@(posedge core_clk) disable iff (reset) // see R8
    (conv_in.valid && conv_in.chan == 5'h18 && conv_in.value > conv_in.high_limit)
    |=> flags_reg[23])
    else $error("last tach flag not set above high limit");

  a_unmapped_read: assert property (@(posedge core_clk) disable iff (reset) // see R9
    (rd_req.en && rd_req.addr == 8'h23) |=> (rd_valid && rd_data == 8'h00))
    else $error("unmapped read not zero");

  a_read_pulse: assert property (@(posedge core_clk) disable iff (reset) // see R9
    !$past(reset) |-> rd_valid == $past(rd_req.en))
    else $error("read valid not one cycle after request");

  c_out_of_limit: cover property (@(posedge core_clk) disable iff (reset)
    conv_in.valid && outside);
  c_alarm_entry: cover property (@(posedge core_clk) disable iff (reset)
    $rose(thermal_alarm_a));
  c_voltage_mode_hit: cover property (@(posedge core_clk) disable iff (reset)
    conv_in.valid && conv_in.chan == 5'h02 && remote_b_voltage_mode && outside);
  c_event_out: cover property (@(posedge core_clk) disable iff (reset)
    limit_event != '0);
  c_tach_read: cover property (@(posedge core_clk) disable iff (reset)
    rd_req.en && rd_req.addr == 8'h22);

endmodule

/* File: sim/mlsf_host_model.sv */
/*
  Host reader of the status port, in place of the serial bus host.
  Assumes one read in flight at a time and a bench that pulses go.
*/
`timescale 1ns/100ps
module mlsf_host_model (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // Bench command
  input  wire logic                   go,
  input  wire logic [7:0]             addr,
  // Status read port
  output mlsf_pkg::mlsf_rd_req_t      rd_req,
  input  wire logic [7:0]             rd_data,
  input  wire logic                   rd_valid,
  // Result
  output logic [7:0]                  got,
  output logic                        done
);
  // Idle address toggles so a stale value never looks like a request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_req <= '0;
      got    <= 8'h00;
      done   <= 1'h0;
    end else begin
      rd_req.en   <= go;
      rd_req.addr <= go ? addr : ~rd_req.addr;
      done        <= rd_valid;
      if (rd_valid) begin
        got <= rd_data;
      end
    end
  end
endmodule

/* File: sim/mlsf_status_bench.sv */
/*
  Self-checking bench for the limit status flags.
  Assumes the host model and one conversion result per cycle.
*/
`timescale 1ns/100ps
module mlsf_status_bench;
  logic                   core_clk = 0;
  logic                   reset    = 1;
  mlsf_pkg::mlsf_conv_t   conv_in  = '0;
  logic                   mode_v   = 0;
  logic [1:0]             alarm    = '0;
  logic [23:0]            mask     = '0;
  logic                   go       = 0;
  logic [7:0]             addr     = '0;
  mlsf_pkg::mlsf_rd_req_t rd_req;
  logic [7:0]             rd_data;
  logic                   rd_valid;
  logic [23:0]            limit_event;
  logic [7:0]             got;
  logic                   done;
  logic [23:0]            flags    = '0;
  int                     n_mismatch = 0;
  int                     checked    = 0;
  always #12.5 core_clk = ~core_clk;
  mlsf_status i_mlsf_status (.core_clk(core_clk), .reset(reset), .conv_in(conv_in),
    .remote_b_voltage_mode(mode_v), .thermal_alarm_a(alarm[0]), .thermal_alarm_b(alarm[1]),
    .event_mask(mask), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid),
    .limit_event(limit_event));
  mlsf_host_model i_mlsf_host_model (.core_clk(core_clk), .reset(reset), .go(go),
    .addr(addr), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid), .got(got),
    .done(done));
  task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge core_clk);
    go   <= 1'h1;
    addr <= a;
    @(posedge core_clk);
    go <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      #1;
      if (done === 1'h1) break;
    end
    chk("read done", {23'h0, done}, 24'h1);
  endtask
  task automatic read_all(string what);
    for (int i = 0; i < 3; i++) begin
      rd(8'h20 + 8'(i));
      chk(what, {16'h0, got}, {16'h0, flags[8*i+:8]});
    end
  endtask
  // One result in, then the event pulse is judged
  task automatic conv(int c, logic [7:0] v, logic [7:0] h, logic [7:0] l, logic [23:0] ev);
    @(posedge core_clk);
    conv_in <= '{1'h1, 5'(c), v, h, l};
    @(posedge core_clk);
    conv_in.valid <= 1'h0;
    #1;
    chk("event", limit_event, ev);
  endtask
  task automatic t_reset();
    repeat (10) @(posedge core_clk);
    reset <= 1'h0;
    flags = '0;
    read_all("reset value");
    rd(8'h23);
    chk("unmapped", {16'h0, got}, 24'h0);
    $display("test reset done");
  endtask
  task automatic t_window();
    int b;
    for (int c = 0; c < 25; c++) begin
      if (c == 2) continue;
      b = c - ((c >= 2) ? 1 : 0);
      conv(c, 8'h90, 8'h80, 8'h10, 24'h1 << b);
      flags[b] = 1'h1;
    end
    conv(2, 8'h40, 8'h80, 8'h10, 24'h0);
    conv(25, 8'h40, 8'h80, 8'h10, 24'h0);
    read_all("above high");
    for (int c = 9; c < 25; c++) begin
      conv(c, 8'h05, 8'h80, 8'h10, (c < 17) ? 24'h1 << (c - 1) : 24'h0);
    end
    flags[23:16] = 8'h00;
    conv(3, 8'h40, 8'h80, 8'h10, 24'h0);
    conv(4, 8'h80, 8'h80, 8'h10, 24'h0);
    flags[3:2] = 2'h0;
    read_all("low and clear");
    mask[2] <= 1'h1;
    conv(3, 8'h90, 8'h80, 8'h10, 24'h0);
    flags[2] = 1'h1;
    read_all("masked flag");
    mask[2] <= 1'h0;
    $display("test window done");
  endtask
  task automatic t_voltage();
    mode_v <= 1'h1;
    conv(1, 8'h40, 8'h80, 8'h10, 24'h0);
    read_all("voltage ignore");
    conv(2, 8'h40, 8'h80, 8'h10, 24'h0);
    flags[1] = 1'h0;
    read_all("voltage clear");
    alarm[1] <= 1'h1;
    read_all("voltage alarm");
    alarm[1] <= 1'h0;
    conv(2, 8'h08, 8'h80, 8'h10, 24'h2);
    flags[1] = 1'h1;
    read_all("voltage set");
    mode_v <= 1'h0;
    $display("test voltage done");
  endtask
  task automatic t_alarm();
    for (int k = 0; k < 2; k++) begin
      conv(k, 8'h40, 8'h80, 8'h10, 24'h0);
      flags[k] = 1'h0;
      read_all("alarm idle");
      alarm[k] <= 1'h1;
      flags[k] = 1'h1;
      read_all("alarm enter");
      conv(k, 8'h40, 8'h80, 8'h10, 24'h0);
      flags[k] = 1'h0;
      read_all("alarm held");
      alarm[k] <= 1'h0;
      flags[k] = 1'h1;
      read_all("alarm leave");
    end
    $display("test alarm done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    t_reset();
    t_window();
    @(posedge core_clk);
    reset <= 1'h1;
    t_reset();
    t_window();
    t_voltage();
    t_alarm();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
